// ===== hdl/fbc_pkg.sv
// Shared constants and types of the fieldbus coupler mode control.
package fbc_pkg;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 20_000_000;
    localparam int FLASH_HALF_MS = 500;
    localparam int FLASH_CYC = FLASH_HALF_MS * (CLK_HZ / 1000);
    localparam int RESP_TMO_US = 1000;
    localparam int RESP_TMO_CYC = RESP_TMO_US * (CLK_HZ / 1_000_000);
    // ----------------------------------------------------------------
    // Station limits
    // ----------------------------------------------------------------
    localparam logic [6:0] MAX_SLV_PLAIN = 7'd31;
    localparam logic [6:0] MAX_SLV_RPT = 7'd126;
    // ----------------------------------------------------------------
    // Register map and fields
    // ----------------------------------------------------------------
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_STATUS = 8'h04;
    localparam logic [7:0] ADR_STATION = 8'h08;
    localparam logic [7:0] ADR_FAULT = 8'h0c;
    localparam logic [7:0] ADR_OPIDX = 8'h10;
    localparam logic [7:0] ADR_OPDATA = 8'h14;
    localparam int CTRL_LOAD = 0;
    localparam int CTRL_ROLE = 1;
    localparam int CTRL_RUN = 2;
    localparam int CTRL_RPT = 3;
    localparam int ST_OWN = 0;
    localparam int ST_OWNER = 8;
    localparam int ST_PLAN = 16;
    localparam int FLT_BUS = 0;
    localparam int FLT_CFG = 1;
    localparam int FLT_ACC = 2;
    localparam logic [6:0] RST_ADDR = 7'h02;
    localparam logic [6:0] RST_OWNER = 7'h01;
    localparam logic [6:0] RST_PLAN = 7'h01;
    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        K_DIAG = 3'h0, K_DX = 3'h1, K_PRM = 3'h2, K_CFG = 3'h3,
        K_RDIO = 3'h4, K_ACK = 3'h5, K_CTRL = 3'h6
    } fbc_kind_e;
    typedef enum logic [1:0] {
        LAMP_OFF = 2'h0, LAMP_FLASH = 2'h1, LAMP_ON = 2'h2
    } fbc_lamp_e;
    typedef struct packed {
        fbc_kind_e kind;
        logic [6:0] src;
        logic [6:0] dst;
        logic [15:0] data;
        logic unready;
    } fbc_frame_s;
endpackage

// ===== hdl/fbc_lamp.sv
// Lamp driver: off, flashing at a fixed half period, or steady.
`timescale 1ns/1ps
module fbc_lamp #(
    parameter int HALF = fbc_pkg::FLASH_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire fbc_pkg::fbc_lamp_e mode,
    output logic lamp
);
    import fbc_pkg::*;
    localparam int CW = $clog2(HALF + 1);
    logic [CW-1:0] cnt_r;
    logic phase_r;
    logic tick;

    assign tick = (cnt_r == CW'(HALF - 1));

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
            phase_r <= 1'b0;
        end else if (tick) begin
            cnt_r <= '0;
            phase_r <= ~phase_r;
        end else begin
            cnt_r <= cnt_r + CW'(1);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lamp <= 1'b0;
        end else begin
            case (mode)
                LAMP_ON: lamp <= 1'b1;
                LAMP_FLASH: lamp <= phase_r;
                default: lamp <= 1'b0;
            endcase
        end
    end
endmodule

// ===== hdl/fbc_opmem.sv
// Operand areas: words taken from the bus and words to be sent.
`timescale 1ns/1ps
module fbc_opmem #(
    parameter int DEPTH = 128,
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic linkWe,
    input wire logic [6:0] linkIdx,
    input wire logic [W-1:0] linkWData,
    output logic [W-1:0] linkRData,
    input wire logic swWe,
    input wire logic [6:0] swIdx,
    input wire logic [W-1:0] swWData,
    output logic [W-1:0] swRData
);
    // Two separate arrays so that software and bus never contend.
    logic [W-1:0] rxArea [DEPTH];
    logic [W-1:0] txArea [DEPTH];

    always_ff @(posedge clk) begin
        if (linkWe) begin
            rxArea[linkIdx] <= linkWData;
        end
    end

    always_ff @(posedge clk) begin
        if (swWe) begin
            txArea[swIdx] <= swWData;
        end
    end

    assign linkRData = txArea[linkIdx];
    assign swRData = rxArea[swIdx];
endmodule

// ===== hdl/fbc_mode_ctrl.sv
// Coupler operating states, role behaviour and Wishbone registers.
//
// Our own choices: the Wishbone register port and the address map.
`timescale 1ns/1ps
// ----------------------------------------------------------------
// ----------------------------------------------------------------
module fbc_mode_ctrl #(
    parameter int FLASH_CYCLES = fbc_pkg::FLASH_CYC,
    parameter int TMO_CYCLES = fbc_pkg::RESP_TMO_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic rxValid,
    input wire fbc_pkg::fbc_frame_s rxFrame,
    input wire logic rxErr,
    output fbc_pkg::fbc_frame_s txFrame,
    output logic txValid,
    output logic readyLamp,
    output logic errLamp,
    output logic [2:0] faultFlags
);
    import fbc_pkg::*;

    typedef enum logic [6:0] {
        S_UNCFG = 7'h01, S_READY = 7'h02, S_SWAIT = 7'h04, S_SDX = 7'h08,
        S_MINIT = 7'h10, S_MCYC = 7'h20, S_MSTOP = 7'h40
    } fbc_state_e;

    localparam int TW = $clog2(TMO_CYCLES + 1);

    fbc_state_e state_r;
    logic role_r, run_r, rpt_r, cfgRole_r, waiting_r;
    logic [6:0] ownAddr_r, owner_r, plan_r, opIdx_r, idx_r;
    logic [2:0] fault_r;
    logic [126:0] active_r;
    logic [TW-1:0] tmo_r;
    logic [31:0] ctrlW, stW, fltW;
    logic wbReq, wbWr, loadPulse, cfgOk, slvSide, forMe, fromOwner;
    logic replyHit, tmoHit, accRefused, memWe, swWe;
    logic [6:0] slot;
    logic [15:0] memTx, memSw;
    logic [2:0] faultSet, faultClr;
    fbc_lamp_e lampMode;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] selMerge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0] sel);
        for (int i = 0; i < 4; i++) begin
            selMerge[8*i +: 8] = sel[i] ? nw[8*i +: 8] : old[8*i +: 8];
        end
    endfunction

    function automatic logic [6:0] nextIdx(input logic [6:0] i,
                                           input logic [6:0] p);
        nextIdx = (i >= p) ? 7'h01 : i + 7'h01;
    endfunction

    // ----------------------------------------------------------------
    // Wishbone slave
    // ----------------------------------------------------------------
    assign wbReq = cyc_i && stb_i && !ack_o;
    assign wbWr = wbReq && we_i;
    assign ctrlW = selMerge({28'h0, rpt_r, run_r, role_r, 1'b0},
                            dat_i, sel_i);
    assign stW = selMerge({9'h0, plan_r, 1'b0, owner_r, 1'b0, ownAddr_r},
                          dat_i, sel_i);
    assign fltW = selMerge(32'h0, dat_i, sel_i);
    assign loadPulse = wbWr && adr_i == ADR_CTRL && ctrlW[CTRL_LOAD];
    assign swWe = wbWr && adr_i == ADR_OPDATA;
    // A plan beyond the segment limit is refused as a bad configuration.
    assign cfgOk = plan_r != 7'h0 &&
        plan_r <= (ctrlW[CTRL_RPT] ? MAX_SLV_RPT : MAX_SLV_PLAIN);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0;
        end else begin
            ack_o <= wbReq;
            if (wbReq && !we_i) begin
                case (adr_i)
                    ADR_CTRL: dat_o <= {28'h0, rpt_r, run_r, role_r, 1'b0};
                    ADR_STATUS: dat_o <= {9'h0, idx_r, 6'h0, |active_r,
                                          cfgRole_r, 1'b0, state_r};
                    ADR_STATION: dat_o <= {9'h0, plan_r, 1'b0, owner_r,
                                           1'b0, ownAddr_r};
                    ADR_FAULT: dat_o <= {29'h0, fault_r};
                    ADR_OPIDX: dat_o <= {25'h0, opIdx_r};
                    ADR_OPDATA: dat_o <= {16'h0, memSw};
                    default: dat_o <= 32'h0;
                endcase
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            role_r <= 1'b0;
            run_r <= 1'b0;
            rpt_r <= 1'b0;
        end else if (wbWr && adr_i == ADR_CTRL) begin
            role_r <= ctrlW[CTRL_ROLE];
            run_r <= ctrlW[CTRL_RUN];
            rpt_r <= ctrlW[CTRL_RPT];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ownAddr_r <= RST_ADDR;
            owner_r <= RST_OWNER;
            plan_r <= RST_PLAN;
            opIdx_r <= 7'h0;
        end else if (wbWr) begin
            if (adr_i == ADR_STATION) begin
                ownAddr_r <= stW[ST_OWN +: 7];
                owner_r <= stW[ST_OWNER +: 7];
                plan_r <= stW[ST_PLAN +: 7];
            end
            if (adr_i == ADR_OPIDX) begin
                opIdx_r <= fltW[6:0];
            end
        end
    end

    // Write one to clear; a fault raised in the same cycle still sticks.
    assign faultClr = (wbWr && adr_i == ADR_FAULT) ? fltW[2:0] : 3'h0;
    assign faultSet = {accRefused, loadPulse && !cfgOk,
                       (rxValid && rxErr) || tmoHit};

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fault_r <= 3'h0;
            faultFlags <= 3'h0;
            errLamp <= 1'b0;
        end else begin
            fault_r <= (fault_r & ~faultClr) | faultSet;
            faultFlags <= fault_r;
            errLamp <= fault_r[FLT_BUS];
        end
    end

    // ----------------------------------------------------------------
    // Receive decode
    // ----------------------------------------------------------------
    assign slvSide = !cfgRole_r &&
        (state_r == S_READY || state_r == S_SWAIT || state_r == S_SDX);
    assign forMe = rxValid && !rxErr && rxFrame.dst == ownAddr_r;
    assign fromOwner = rxFrame.src == owner_r;
    // Only the polled planned slave is heard; other masters are ignored.
    assign replyHit = waiting_r && forMe && rxFrame.src == idx_r;
    assign tmoHit = waiting_r && !replyHit && tmo_r == TW'(TMO_CYCLES - 1);
    assign accRefused = slvSide && forMe && run_r && !fromOwner &&
        (rxFrame.kind == K_PRM || rxFrame.kind == K_CFG ||
         rxFrame.kind == K_DX);
    assign slot = cfgRole_r ? idx_r : 7'h0;
    assign memWe = cfgRole_r ? (replyHit && rxFrame.kind == K_DX) :
        (slvSide && state_r == S_SDX && forMe && run_r && fromOwner &&
         rxFrame.kind == K_DX);

    fbc_opmem #(.DEPTH(128), .W(16)) u_mem (
        .clk(clk),
        .linkWe(memWe),
        .linkIdx(slot),
        .linkWData(rxFrame.data),
        .linkRData(memTx),
        .swWe(swWe),
        .swIdx(opIdx_r),
        .swWData(dat_i[15:0]),
        .swRData(memSw)
    );

    // ----------------------------------------------------------------
    // Operating states and transmission
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= S_UNCFG;
            cfgRole_r <= 1'b0;
            idx_r <= 7'h01;
            waiting_r <= 1'b0;
            tmo_r <= '0;
            active_r <= '0;
            txValid <= 1'b0;
            txFrame <= '0;
        end else begin
            txValid <= 1'b0;
            txFrame.src <= ownAddr_r;
            txFrame.unready <= !run_r;
            if (loadPulse && (state_r == S_UNCFG || state_r == S_READY)) begin
                state_r <= cfgOk ? S_READY : S_UNCFG;
                cfgRole_r <= ctrlW[CTRL_ROLE];
            end else begin
                case (state_r)
                    S_READY: begin
                        if (run_r) begin
                            state_r <= cfgRole_r ? S_MINIT : S_SWAIT;
                            idx_r <= 7'h01;
                            waiting_r <= 1'b0;
                        end
                    end
                    S_SWAIT: begin
                        if (!run_r) begin
                            state_r <= S_READY;
                        end else if (forMe && fromOwner &&
                                     rxFrame.kind == K_CFG) begin
                            state_r <= S_SDX;
                        end
                    end
                    S_SDX: begin
                        if (!run_r) begin
                            state_r <= S_READY;
                        end
                    end
                    S_MINIT, S_MCYC: begin
                        if (!waiting_r) begin
                            if (!run_r) begin
                                state_r <= S_MSTOP;
                                idx_r <= 7'h01;
                            end else begin
                                txValid <= 1'b1;
                                txFrame.dst <= idx_r;
                                txFrame.kind <= active_r[idx_r] ?
                                    K_DX : K_PRM;
                                txFrame.data <= memTx;
                                waiting_r <= 1'b1;
                                tmo_r <= '0;
                            end
                        end else if (replyHit || tmoHit) begin
                            active_r[idx_r] <= replyHit &&
                                (rxFrame.kind == K_ACK ||
                                 (rxFrame.kind == K_DX &&
                                  active_r[idx_r]));
                            waiting_r <= 1'b0;
                            idx_r <= nextIdx(idx_r, plan_r);
                            if (idx_r >= plan_r) begin
                                state_r <= S_MCYC;
                            end
                        end else begin
                            tmo_r <= tmo_r + TW'(1);
                        end
                    end
                    S_MSTOP: begin
                        // Each admitted slave is told to leave before idling.
                        if (active_r[idx_r]) begin
                            txValid <= 1'b1;
                            txFrame.dst <= idx_r;
                            txFrame.kind <= K_CTRL;
                            txFrame.data <= 16'h0;
                            active_r[idx_r] <= 1'b0;
                        end
                        idx_r <= nextIdx(idx_r, plan_r);
                        if (idx_r >= plan_r) begin
                            state_r <= S_READY;
                        end
                    end
                    default: state_r <= state_r;
                endcase
            end
            if (slvSide && forMe) begin
                txFrame.dst <= rxFrame.src;
                txFrame.data <= memTx;
                case (rxFrame.kind)
                    K_DIAG: begin
                        txValid <= 1'b1;
                        txFrame.kind <= K_DIAG;
                    end
                    K_PRM, K_CFG: begin
                        txValid <= run_r && fromOwner;
                        txFrame.kind <= K_ACK;
                    end
                    K_DX: begin
                        txValid <= run_r && fromOwner &&
                            state_r == S_SDX;
                        txFrame.kind <= K_DX;
                    end
                    K_RDIO: begin
                        txValid <= run_r;
                        txFrame.kind <= K_RDIO;
                    end
                    default: txValid <= 1'b0;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Ready lamp
    // ----------------------------------------------------------------
    always_comb begin
        if (state_r == S_UNCFG) begin
            lampMode = LAMP_OFF;
        end else if (cfgRole_r ? |active_r : state_r == S_SDX) begin
            lampMode = LAMP_ON;
        end else begin
            lampMode = LAMP_FLASH;
        end
    end

    fbc_lamp #(.HALF(FLASH_CYCLES)) u_lamp (
        .clk(clk),
        .rst(rst),
        .mode(lampMode),
        .lamp(readyLamp)
    );

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence slvDiagStopped;
        slvSide && forMe && !run_r && rxFrame.kind == K_DIAG;
    endsequence

    quiet_unconfig_a: assert property (
        state_r == S_UNCFG && !loadPulse |=> !txValid ##1 !readyLamp)
        else $error("unconfigured coupler transmitted or lit lamp");
    cfg_load_a: assert property (
        loadPulse && state_r == S_UNCFG && cfgOk |=>
        state_r == S_READY && cfgRole_r == $past(ctrlW[CTRL_ROLE]))
        else $error("configuration load did not set role and ready");
    diag_unready_a: assert property (
        slvDiagStopped |=> txValid && txFrame.unready &&
        txFrame.kind == K_DIAG)
        else $error("diagnosis answer lacks unready flag");
    dx_ignored_a: assert property (
        slvSide && forMe && !run_r && rxFrame.kind == K_DX |=> !txValid)
        else $error("exchange answered while program stopped");
    slave_steady_a: assert property (
        state_r == S_SDX [*2] |-> readyLamp)
        else $error("admitted slave lamp not steady");
    withdraw_a: assert property (
        slvSide && state_r == S_SDX && !run_r && !loadPulse |=>
        state_r == S_READY)
        else $error("slave did not withdraw on stop");
    dx_only_active_a: assert property (
        txValid && cfgRole_r && txFrame.kind == K_DX |->
        $past(active_r[idx_r]))
        else $error("exchange sent to uninitialised slave");
    master_steady_a: assert property (
        cfgRole_r && |active_r && state_r != S_UNCFG |=> readyLamp)
        else $error("master lamp not steady with slave active");
    orderly_stop_a: assert property (
        state_r == S_MCYC && !run_r && !waiting_r && !loadPulse |=>
        state_r == S_MSTOP)
        else $error("master did not enter shutdown");
    foreign_refused_a: assert property (
        accRefused |=> !txValid && fault_r[FLT_ACC])
        else $error("foreign master access not refused");
    err_lamp_a: assert property (
        rxValid && rxErr |=> ##1 errLamp)
        else $error("error lamp not lit on bus error");
endmodule

// ===== verification/fbc_remote.sv
// Remote field bus station model facing the coupler's link side.
`timescale 1ns/1ps
module fbc_remote (
    input wire logic clk,
    input wire logic autoAns,
    input wire logic txValid,
    input wire fbc_pkg::fbc_frame_s txFrame,
    output logic rxValid,
    output fbc_pkg::fbc_frame_s rxFrame,
    output logic rxErr
);
    import fbc_pkg::*;
    localparam logic [6:0] PRESENT = 7'h01;
    initial begin
        rxValid = 1'b0;
        rxFrame = '0;
        rxErr = 1'b0;
    end
    // The frame lines are inverted once a frame is over, so a design that
    // reads them outside rxValid cannot see a stale but plausible frame.
    task automatic send(input fbc_kind_e k, input logic [6:0] s, d,
                        input logic [15:0] v, input logic e);
        @(posedge clk);
        rxValid <= 1'b1;
        rxFrame <= '{k, s, d, v, 1'b0};
        rxErr <= e;
        @(posedge clk);
        rxValid <= 1'b0;
        rxErr <= 1'b0;
        rxFrame <= ~rxFrame;
    endtask
    // Only one planned station answers; the other stays silent on purpose.
    always @(posedge clk) begin
        if (autoAns && txValid && txFrame.dst == PRESENT &&
            (txFrame.kind == K_PRM || txFrame.kind == K_DX)) begin
            send(txFrame.kind == K_PRM ? K_ACK : K_DX, PRESENT,
                 txFrame.src, 16'h55aa, 1'b0);
        end
    end
endmodule

// ===== verification/tb.sv
// Self-checking bench for the coupler mode control.
`timescale 1ns/1ps
module tb;
    import fbc_pkg::*;
    logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, autoAns = 0;
    logic [7:0] adr = '0;
    logic [3:0] sel = '0;
    logic [31:0] dat = '0, dato, q;
    logic ack, rxValid, rxErr, txValid, readyLamp, errLamp;
    logic [2:0] faultFlags;
    fbc_frame_s rxFrame, txFrame, lastTx;
    int num_errors = 0, checks_done = 0, txCnt = 0, ctrlCnt = 0, hi, n0;
    always #25 clk = ~clk;
    fbc_mode_ctrl #(.FLASH_CYCLES(4), .TMO_CYCLES(8)) uut (.clk(clk),
        .rst(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(sel), .dat_i(dat), .dat_o(dato), .ack_o(ack),
        .rxValid(rxValid), .rxFrame(rxFrame), .rxErr(rxErr),
        .txFrame(txFrame), .txValid(txValid), .readyLamp(readyLamp),
        .errLamp(errLamp), .faultFlags(faultFlags));
    fbc_remote pm (.clk(clk), .autoAns(autoAns), .txValid(txValid),
        .txFrame(txFrame), .rxValid(rxValid), .rxFrame(rxFrame),
        .rxErr(rxErr));
    always @(posedge clk) begin
        if (txValid === 1'b1) begin
            lastTx <= txFrame;
            txCnt <= txCnt + 1;
            ctrlCnt <= ctrlCnt + (txFrame.kind === K_CTRL);
        end
    end
    // ----------------------------------------------------------------
    // Access and compare tasks
    // ----------------------------------------------------------------
    task automatic chk(input string n, input logic [31:0] e, g);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hf;
        do @(posedge clk); while (ack !== 1'b1);
        q = dato;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, e,
                      input string n);
        wb(1'b0, a, 32'h0);
        chk(n, e, q & m);
    endtask
    task automatic lnk(input fbc_kind_e k, input logic [6:0] s,
                       input logic [15:0] v, input logic e, input int x);
        n0 = txCnt;
        pm.send(k, s, 7'h02, v, e);
        repeat (3) @(posedge clk);
        chk("answers", x, txCnt - n0);
    endtask
    task automatic samp;
        hi = 0;
        repeat (12) begin
            @(posedge clk);
            hi += (readyLamp === 1'b1);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // The whole sequence needs well under a thousand cycles.
    initial begin
        #(50 * 4000);
        num_errors++;
        wrap_up;
    end
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd(ADR_STATUS, 32'h3ff, 32'h1, "status");
        samp;
        chk("lamp off", 0, hi);
        chk("silent", 0, txCnt);
        wb(1'b1, ADR_STATION, 32'h0020_0102);
        wb(1'b1, ADR_CTRL, 32'h1);
        rd(ADR_FAULT, 32'h7, 32'h2, "bad plan");
        chk("flags", 32'h2, faultFlags);
        rd(ADR_STATUS, 32'h3ff, 32'h1, "status");
        wb(1'b1, ADR_FAULT, 32'h2);
        wb(1'b1, ADR_STATION, 32'h0002_0102);
        wb(1'b1, ADR_CTRL, 32'h1);
        rd(ADR_STATUS, 32'h3ff, 32'h2, "status");
        rd(8'h20, 32'hffff_ffff, 32'h0, "unmapped");
        samp;
        chk("flash", 1, hi > 0 && hi < 12);
        lnk(K_DIAG, 7'h01, 16'h0, 1'b0, 1);
        chk("unready", 1, lastTx.unready);
        chk("diag kind", K_DIAG, lastTx.kind);
        chk("diag src", 2, lastTx.src);
        lnk(K_DX, 7'h01, 16'h0, 1'b0, 0);
        wb(1'b1, ADR_CTRL, 32'h4);
        lnk(K_DIAG, 7'h01, 16'h0, 1'b0, 1);
        chk("unready", 0, lastTx.unready);
        chk("diag dst", 1, lastTx.dst);
        lnk(K_CFG, 7'h05, 16'h0, 1'b0, 0);
        rd(ADR_FAULT, 32'h7, 32'h4, "foreign");
        lnk(K_RDIO, 7'h05, 16'h0, 1'b0, 1);
        lnk(K_DIAG, 7'h01, 16'h0, 1'b1, 0);
        rd(ADR_FAULT, 32'h7, 32'h5, "bus err");
        chk("errLamp", 1, errLamp);
        chk("flags", 32'h5, faultFlags);
        wb(1'b1, ADR_FAULT, 32'h7);
        lnk(K_PRM, 7'h01, 16'h0, 1'b0, 1);
        lnk(K_CFG, 7'h01, 16'h0, 1'b0, 1);
        chk("ack kind", K_ACK, lastTx.kind);
        rd(ADR_STATUS, 32'h3ff, 32'h8, "status");
        samp;
        chk("steady", 12, hi);
        wb(1'b1, ADR_OPIDX, 32'h0);
        wb(1'b1, ADR_OPDATA, 32'hbeef);
        lnk(K_DX, 7'h01, 16'h1234, 1'b0, 1);
        chk("dx out", 32'hbeef, lastTx.data);
        rd(ADR_OPDATA, 32'hffff, 32'h1234, "dx in");
        wb(1'b1, ADR_CTRL, 32'h0);
        rd(ADR_STATUS, 32'h3ff, 32'h2, "status");
        autoAns <= 1'b1;
        wb(1'b1, ADR_CTRL, 32'h3);
        n0 = txCnt;
        repeat (20) @(posedge clk);
        chk("idle", n0, txCnt);
        wb(1'b1, ADR_CTRL, 32'h6);
        repeat (80) @(posedge clk);
        rd(ADR_STATUS, 32'h300, 32'h300, "active");
        samp;
        chk("steady", 12, hi);
        rd(ADR_FAULT, 32'h1, 32'h1, "timeout");
        wb(1'b1, ADR_OPIDX, 32'h1);
        rd(ADR_OPDATA, 32'hffff, 32'h55aa, "rx");
        wb(1'b1, ADR_CTRL, 32'h2);
        repeat (40) @(posedge clk);
        chk("ctrl", 1, ctrlCnt);
        chk("ctrl dst", 1, lastTx.dst);
        rd(ADR_STATUS, 32'h37f, 32'h102, "status");
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(ADR_STATUS, 32'h3ff, 32'h1, "status");
        rd(ADR_STATION, 32'h7f7f7f, 32'h0001_0102, "station");
        wb(1'b1, ADR_STATION, 32'h0020_0102);
        wb(1'b1, ADR_CTRL, 32'h9);
        rd(ADR_STATUS, 32'h3ff, 32'h2, "status");
        rd(ADR_FAULT, 32'h7, 32'h0, "reload");
        wrap_up;
    end
endmodule
